/* File: rtl/rst_ctrl_pkg.sv */
// Shared constants, types and register map of the reset source controller
package rst_ctrl_pkg;

    // Bus widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_FLAGS = 6'h00;
    localparam logic [5:0] IDX_SWRESET = 6'h01;
    localparam logic [5:0] IDX_GUARD = 6'h02;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h03;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h04;

    // Byte addresses derived from the indices
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SWRESET = {IDX_SWRESET, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_GUARD = {IDX_GUARD, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // Cause flag layout, bit 0 upward
    localparam int unsigned NUM_CAUSES = 6;
    localparam int unsigned BIT_POR = 0;
    localparam int unsigned BIT_BOD = 1;
    localparam int unsigned BIT_PIN = 2;
    localparam int unsigned BIT_WDT = 3;
    localparam int unsigned BIT_SW = 4;
    localparam int unsigned BIT_DBG = 5;
    localparam int unsigned BIT_TRIGGER = 0;

    // Values after reset
    localparam logic [NUM_CAUSES-1:0] FLAGS_RESET = 6'h01;
    localparam logic [NUM_CAUSES-1:0] IRQ_STATUS_RESET = 6'h00;
    localparam logic [NUM_CAUSES-1:0] IRQ_MASK_RESET = 6'h00;

    // Unlock key for the guard register; value is arbitrary
    localparam logic [7:0] IO_UNLOCK_KEY = 8'h5a;
    // Bus accesses allowed after key write, the protected write included
    localparam int unsigned UNLOCK_W = 3;
    localparam logic [UNLOCK_W-1:0] UNLOCK_WINDOW = 3'h4;

    // Start-up delay: (fuse value + 1) steps of this many cycles
    localparam int unsigned STARTUP_FUSE_W = 3;
    localparam int unsigned STARTUP_STEP_CYCLES = 16;
    localparam int unsigned DELAY_CNT_W = 16;

    // One bit per reset source, same layout as the flags
    typedef struct packed {
        logic dbg;
        logic sw;
        logic wdt;
        logic pin;
        logic brownout_detector;
        logic por;
    } cause_t;

    // Reset sequence, Gray coded along hold, delay, scan, run
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_SCAN = 2'b11,
        ST_RUN = 2'b10
    } seq_state_t;

endpackage

/* File: rtl/sticky_bit.sv */
// One sticky flag bit where a set outranks a clear
module sticky_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic clr,
    output logic q
);

    // Set wins over clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= RESET_VAL;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule // sticky_bit

/* File: rtl/reset_source_controller.sv */
// Reset source controller: source gating, reset sequence, cause flags, APB registers
//
// Behaviour
// - Hold reset while any source is active
// - Stretch initialization by start-up fuse delay
// - Wait for memory scan when fuse asks
// - Stay fully active in every sleep mode
// - Trigger write only within four accesses after key
// - Locked trigger write changes nothing, no reset
// - Flags clear on writing one, zero keeps
// - Power-on clears all flags but power-on flag
// - Set matching cause flag, bits five to zero
// - After power-on only power-on flag set
// - No other flag before first full boot
// - Power-on flag cleared only by software
// - Unlocked one to trigger bit resets device
// - Trigger bit always reads zero
// - Software reset starts at once, full sequence
// - Reset pin counts only when fuse enables
// - User resets spare debug port, brown-out config
module reset_source_controller
    import rst_ctrl_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = STARTUP_STEP_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Reset sources
    input wire logic POR_ACTIVE,
    input wire logic BOD_ACTIVE,
    input wire logic RESET_PIN_N,
    input wire logic WDT_RESET_REQ,
    input wire logic DEBUG_RESET_REQ,
    // Fuses
    input wire logic PIN_RESET_EN_FUSE,
    input wire logic [STARTUP_FUSE_W-1:0] STARTUP_DELAY_FUSE,
    input wire logic STARTUP_SCAN_SELECT_FUSE,
    // Memory scan checker handshake
    input wire logic SCAN_DONE,
    output logic SCAN_START,
    // Reset outputs
    output logic CORE_RESET_N,
    output logic DEBUG_RESET_N,
    output logic BOD_CFG_RESET_N,
    output logic FUSE_RELOAD,
    output logic IRQ
);

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // Sequencer state
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [DELAY_CNT_W-1:0] delay_cnt_reg; // Remaining start-up cycles
    logic [DELAY_CNT_W-1:0] delay_load; // Start-up length from fuse
    logic boot_done_reg; // First full boot since power-on finished

    // Register state
    logic [NUM_CAUSES-1:0] flags_q; // Reset cause flags
    logic [NUM_CAUSES-1:0] status_q; // Interrupt status
    logic [NUM_CAUSES-1:0] mask_reg; // Interrupt mask
    logic [UNLOCK_W-1:0] unlock_cnt_reg; // Open unlock window
    logic sw_pulse_reg; // Software reset request, one cycle

    // Bus decode
    logic acc; // Access phase
    logic done; // Transfer completes this edge
    logic hit; // Mapped address
    logic wr_low; // Completing write with low byte lane
    logic [DATA_W-1:0] rdata; // Read mux

    // Source gathering
    cause_t src; // Active sources this cycle
    logic any_src; // Any source active
    logic [NUM_CAUSES-1:0] flag_set; // Cause flag set terms
    logic [NUM_CAUSES-1:0] flag_clr; // Cause flag clear terms
    logic [NUM_CAUSES-1:0] status_set; // New cause events
    logic status_rd; // Status register read completes

    // Output flops
    logic pready_reg;
    logic pslverr_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic scan_start_reg;
    logic core_reset_n_reg;
    logic debug_reset_n_reg;
    logic bod_cfg_reset_n_reg;
    logic fuse_reload_reg;
    logic irq_reg;

    // Gather sources; no sleep input exists, detection never stops
    // always active
    always_comb begin
        src.por = POR_ACTIVE;
        src.brownout_detector = BOD_ACTIVE;
        src.pin = PIN_RESET_EN_FUSE & ~RESET_PIN_N;
        src.wdt = WDT_RESET_REQ;
        src.sw = sw_pulse_reg;
        src.dbg = DEBUG_RESET_REQ;
        any_src = |src;
    end

    // Start-up length from the delay fuse
    assign delay_load = DELAY_CNT_W'((32'(STARTUP_DELAY_FUSE) + 32'd1) * STEP_CYCLES - 32'd1);

    // Next state of the reset sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            // Wait until every source releases
            ST_HOLD: begin
                state_next = ST_DELAY;
            end
            // Count down the start-up delay
            ST_DELAY: begin
                if (delay_cnt_reg == '0) begin
                    state_next = STARTUP_SCAN_SELECT_FUSE ? ST_SCAN : ST_RUN;
                end
            end
            // Wait for the memory scan result
            ST_SCAN: begin
                if (SCAN_DONE) begin
                    state_next = ST_RUN;
                end
            end
            // Normal operation
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        if (any_src) begin
            state_next = ST_HOLD;
        end
    end

    // Sequencer state register
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Start-up delay counter
    // fuse delay count
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            delay_cnt_reg <= '0;
        end else if (state_next == ST_DELAY && state_reg != ST_DELAY) begin
            delay_cnt_reg <= delay_load;
        end else if (state_reg == ST_DELAY && delay_cnt_reg != '0) begin
            delay_cnt_reg <= delay_cnt_reg - 1'b1;
        end
    end

    // Boot-complete marker, cleared by power-on
    // boot gate
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            boot_done_reg <= 1'b0;
        end else if (POR_ACTIVE) begin
            boot_done_reg <= 1'b0;
        end else if (state_reg == ST_RUN) begin
            boot_done_reg <= 1'b1;
        end
    end

    // Reset outputs, all registered
    // reset domains
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            core_reset_n_reg <= 1'b0;
            debug_reset_n_reg <= 1'b0;
            bod_cfg_reset_n_reg <= 1'b0;
            fuse_reload_reg <= 1'b0;
            scan_start_reg <= 1'b0;
        end else begin
            core_reset_n_reg <= (state_next == ST_RUN);
            // Debug port only falls with the supply resets
            debug_reset_n_reg <= ~(POR_ACTIVE | BOD_ACTIVE);
            // Brown-out configuration only falls with power-on
            bod_cfg_reset_n_reg <= ~POR_ACTIVE;
            // Fuses reload once every source has released
            fuse_reload_reg <= (state_reg == ST_HOLD) && (state_next == ST_DELAY);
            scan_start_reg <= (state_reg == ST_DELAY) && (state_next == ST_SCAN);
        end
    end

    // APB decode; one wait state, answer on the second access cycle
    always_comb begin
        acc = PSEL & PENABLE;
        done = acc & pready_reg;
        hit = (PADDR == ADDR_FLAGS) || (PADDR == ADDR_SWRESET) || (PADDR == ADDR_GUARD)
            || (PADDR == ADDR_IRQ_STATUS) || (PADDR == ADDR_IRQ_MASK);
        wr_low = done & PWRITE & PSTRB[0] & hit;
        status_rd = done & ~PWRITE & (PADDR == ADDR_IRQ_STATUS);
    end

    // Read mux; the trigger register has no storage behind it
    // trigger reads zero
    always_comb begin
        rdata = '0;
        case (PADDR)
            ADDR_FLAGS: rdata = {{(DATA_W-NUM_CAUSES){1'b0}}, flags_q};
            ADDR_SWRESET: rdata = '0;
            ADDR_GUARD: rdata = {{(DATA_W-UNLOCK_W){1'b0}}, unlock_cnt_reg};
            ADDR_IRQ_STATUS: rdata = {{(DATA_W-NUM_CAUSES){1'b0}}, status_q};
            ADDR_IRQ_MASK: rdata = {{(DATA_W-NUM_CAUSES){1'b0}}, mask_reg};
            default: rdata = '0;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= acc & ~pready_reg;
            if (acc && !pready_reg) begin
                pslverr_reg <= ~hit;
                prdata_reg <= PWRITE ? '0 : rdata;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Unlock window: opened by the key, shortened by each access
    // unlock window
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            unlock_cnt_reg <= '0;
        end else if (wr_low && PADDR == ADDR_GUARD && PWDATA[7:0] == IO_UNLOCK_KEY) begin
            unlock_cnt_reg <= UNLOCK_WINDOW;
        end else if (wr_low && PADDR == ADDR_SWRESET) begin
            // A protected write uses up the window
            unlock_cnt_reg <= '0;
        end else if (done && unlock_cnt_reg != '0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 1'b1;
        end
    end

    // Software reset request; locked writes fall through
    // locked write ignored
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sw_pulse_reg <= 1'b0;
        end else begin
            sw_pulse_reg <= wr_low && (PADDR == ADDR_SWRESET) && PWDATA[BIT_TRIGGER]
                && (unlock_cnt_reg != '0);
        end
    end

    // Interrupt mask register
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            mask_reg <= IRQ_MASK_RESET;
        end else if (wr_low && PADDR == ADDR_IRQ_MASK) begin
            mask_reg <= PWDATA[NUM_CAUSES-1:0];
        end
    end

    // Flag set and clear terms
    // cause flags
    always_comb begin
        flag_set = src & {NUM_CAUSES{boot_done_reg & ~POR_ACTIVE}};
        flag_set[BIT_POR] = POR_ACTIVE;
        flag_clr = (wr_low && PADDR == ADDR_FLAGS) ? PWDATA[NUM_CAUSES-1:0] : '0;
        flag_clr[NUM_CAUSES-1:1] = flag_clr[NUM_CAUSES-1:1] | {(NUM_CAUSES-1){POR_ACTIVE}};
        status_set = flag_set & ~flags_q;
    end

    // Flag and interrupt status bits, set over clear
    // write one clear
    for (genvar i = 0; i < NUM_CAUSES; i++) begin : g_bits
        sticky_bit #(
            .RESET_VAL(FLAGS_RESET[i])
        ) u_flag (
            .clk(CLK_SYS),
            .nrst(NRST),
            .set(flag_set[i]),
            .clr(flag_clr[i]),
            .q(flags_q[i])
        );
        sticky_bit #(
            .RESET_VAL(IRQ_STATUS_RESET[i])
        ) u_status (
            .clk(CLK_SYS),
            .nrst(NRST),
            .set(status_set[i]),
            .clr(status_rd),
            .q(status_q[i])
        );
    end

    // Level interrupt from unmasked status
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_q & mask_reg);
        end
    end

    // Port drive
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign SCAN_START = scan_start_reg;
    assign CORE_RESET_N = core_reset_n_reg;
    assign DEBUG_RESET_N = debug_reset_n_reg;
    assign BOD_CFG_RESET_N = bod_cfg_reset_n_reg;
    assign FUSE_RELOAD = fuse_reload_reg;
    assign IRQ = irq_reg;

    // Key write and protected trigger write
    sequence s_key_write;
        wr_low && PADDR == ADDR_GUARD && PWDATA[7:0] == IO_UNLOCK_KEY;
    endsequence
    sequence s_trigger_write;
        wr_low && PADDR == ADDR_SWRESET && PWDATA[BIT_TRIGGER];
    endsequence

    a_src_holds_core: assert property (any_src |=> !CORE_RESET_N && state_reg == ST_HOLD)
        else $error("Core reset released while a source was active");
    a_delay_stretch: assert property (
        (state_reg == ST_DELAY && delay_cnt_reg != '0 && !any_src) |=> state_reg == ST_DELAY)
        else $error("Start-up delay cut short");
    a_scan_wait: assert property (
        (state_reg == ST_SCAN && !SCAN_DONE && !any_src) |=> state_reg == ST_SCAN && !CORE_RESET_N)
        else $error("Left scan wait before scan finished");
    a_key_opens: assert property (s_key_write |=> unlock_cnt_reg == 3'h4)
        else $error("Unlock key did not open four-access window");
    a_locked_write: assert property (
        (s_trigger_write and (unlock_cnt_reg == '0)) |=> !sw_pulse_reg ##1 CORE_RESET_N == $past(CORE_RESET_N, 2) || any_src)
        else $error("Locked trigger write caused a reset");
    a_sw_fires: assert property (
        (s_trigger_write and (unlock_cnt_reg != '0)) |=> sw_pulse_reg ##1 !CORE_RESET_N && state_reg == ST_HOLD)
        else $error("Unlocked trigger write did not reset");
    a_w1c_flags: assert property (
        (wr_low && PADDR == ADDR_FLAGS && PWDATA[BIT_WDT] && !flag_set[BIT_WDT]) |=> !flags_q[BIT_WDT])
        else $error("Write one did not clear watchdog flag");
    a_por_only: assert property (POR_ACTIVE |=> flags_q == 6'h01)
        else $error("Power-on left flags other than power-on flag");
    a_power_on_flag_kept: assert property (
        (flags_q[BIT_POR] && !(wr_low && PADDR == ADDR_FLAGS && PWDATA[BIT_POR])) |=> flags_q[BIT_POR])
        else $error("Power-on flag cleared without software write");
    a_trigger_zero: assert property (
        (acc && !pready_reg && !PWRITE && PADDR == ADDR_SWRESET) |=> PREADY && PRDATA == '0)
        else $error("Trigger register read back non-zero");
    a_pin_gated: assert property (
        (!PIN_RESET_EN_FUSE && !RESET_PIN_N && boot_done_reg && !POR_ACTIVE && !flags_q[BIT_PIN])
        |=> !flags_q[BIT_PIN])
        else $error("Disabled reset pin set its flag");
    a_set_wins: assert property (
        (flag_set[BIT_WDT] && flag_clr[BIT_WDT]) |=> flags_q[BIT_WDT])
        else $error("Clear beat a coinciding watchdog flag set");

endmodule // reset_source_controller

/* File: testbench/reset_source_controller_tb.sv */
// Self-checking bench for the reset source controller
module reset_source_controller_tb import rst_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Short delay steps keep boot times small
    localparam int STEP = 2;

    // Clock starts low
    logic CLK_SYS = 1'b0;
    logic NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [ADDR_W-1:0] PADDR;
    logic [DATA_W-1:0] PWDATA, PRDATA;
    logic [3:0] PSTRB;
    logic PIN_RESET_EN_FUSE, STARTUP_SCAN_SELECT_FUSE, SCAN_DONE, SCAN_START;
    logic [STARTUP_FUSE_W-1:0] STARTUP_DELAY_FUSE;
    logic CORE_RESET_N, DEBUG_RESET_N, BOD_CFG_RESET_N, FUSE_RELOAD, IRQ;
    // Source requests, laid out like the cause flags
    logic [5:0] src;
    int mismatches, checks_done, n, n0, n1, r;
    // Side effects seen during one reset
    logic reload_seen, dbg_low, cfg_low, err;
    logic [31:0] rdat, w;
    // Expected cause flags
    logic [5:0] ef;
    int bits[4] = '{2, 3, 5, 1};
    logic dl[4] = '{0, 0, 0, 1};

    // Device under test
    reset_source_controller #(.STEP_CYCLES(STEP)) u_dut (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .POR_ACTIVE(src[0]), .BOD_ACTIVE(src[1]), .RESET_PIN_N(~src[2]),
        .WDT_RESET_REQ(src[3]), .DEBUG_RESET_REQ(src[5]),
        .PIN_RESET_EN_FUSE(PIN_RESET_EN_FUSE), .STARTUP_DELAY_FUSE(STARTUP_DELAY_FUSE),
        .STARTUP_SCAN_SELECT_FUSE(STARTUP_SCAN_SELECT_FUSE), .SCAN_DONE(SCAN_DONE),
        .SCAN_START(SCAN_START), .CORE_RESET_N(CORE_RESET_N), .DEBUG_RESET_N(DEBUG_RESET_N),
        .BOD_CFG_RESET_N(BOD_CFG_RESET_N), .FUSE_RELOAD(FUSE_RELOAD), .IRQ(IRQ)
    );

    // 200 MHz clock
    always #2.5 CLK_SYS = ~CLK_SYS;

    // Record reload pulse and side resets
    always @(posedge CLK_SYS) begin
        if (FUSE_RELOAD === 1'b1) reload_seen <= 1'b1;
        if (DEBUG_RESET_N === 1'b0) dbg_low <= 1'b1;
        if (BOD_CFG_RESET_N === 1'b0) cfg_low <= 1'b1;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Expected flags after a write-one-to-clear
    function automatic logic [5:0] w1c(logic [5:0] f, logic [31:0] wd);
        return f & ~wd[5:0];
    endfunction

    // One APB transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge CLK_SYS);
        PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= wd; PSTRB <= 4'hf;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        if (k >= 50) check(1'b0, 1'b1, "bus answer");
    endtask

    // Register write and read shorthands
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x, err);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d, err);
    endtask

    // Count cycles until the core leaves reset
    task automatic wait_boot(output int c);
        c = 0;
        while (CORE_RESET_N !== 1'b1 && c < 3000) begin
            @(posedge CLK_SYS);
            c++;
        end
        if (c >= 3000) check(1'b0, 1'b1, "boot wait");
    endtask

    // Raise one source for len cycles, then let the device boot
    task automatic fire(input int b, input int len, input logic held, output int c);
        @(posedge CLK_SYS);
        reload_seen = 1'b0; dbg_low = 1'b0; cfg_low = 1'b0;
        src[b] <= 1'b1;
        repeat (len) @(posedge CLK_SYS);
        check(CORE_RESET_N, !held, "core hold");
        src[b] <= 1'b0;
        wait_boot(c);
    endtask

    // Hang guard
    initial begin
        #200000;
        mismatches++;
        $display("ERROR %0t: run timed out", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        NRST = 0; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = '0; PWDATA = '0; PSTRB = '0;
        src = '0; PIN_RESET_EN_FUSE = 0; STARTUP_DELAY_FUSE = '0;
        STARTUP_SCAN_SELECT_FUSE = 0; SCAN_DONE = 0; mismatches = 0; checks_done = 0;
        reload_seen = 0; dbg_low = 0; cfg_low = 0;
        void'($urandom(32'h06e3));
        repeat (3) @(posedge CLK_SYS);
        NRST <= 1'b1;
        wait_boot(n);
        rd(ADDR_FLAGS, rdat); check(rdat, 32'h01, "flags after power-up");
        rd(ADDR_SWRESET, rdat); check(rdat, 32'h0, "trigger readback");
        rd(ADDR_IRQ_MASK, rdat); check(rdat, 32'h0, "mask reset value");
        rd(8'h14, rdat); check(rdat, 32'h0, "unmapped read data");
        check({31'h0, err}, 32'h1, "unmapped read error");
        r = $urandom_range(7, 1);
        fire(0, 3, 1'b1, n0);
        STARTUP_DELAY_FUSE <= r[STARTUP_FUSE_W-1:0];
        fire(0, 3, 1'b1, n1);
        check(32'(n1 - n0), 32'(r * STEP), "delay growth");
        STARTUP_DELAY_FUSE <= '0;
        fire(2, 6, 1'b0, n);
        rd(ADDR_FLAGS, rdat); check(rdat, 32'h01, "pin ignored");
        PIN_RESET_EN_FUSE <= 1'b1;
        ef = 6'h01;
        foreach (bits[i]) begin
            fire(bits[i], 4, 1'b1, n);
            ef[bits[i]] = 1'b1;
            rd(ADDR_FLAGS, rdat); check(rdat, {26'h0, ef}, "cause flags");
            check(reload_seen, 1'b1, "fuse reload");
            check(dbg_low, dl[i], "debug reset");
            check(cfg_low, 1'b0, "brown-out config reset");
        end
        repeat (4) begin
            w = $urandom;
            wr(ADDR_FLAGS, w);
            ef = w1c(ef, w);
            rd(ADDR_FLAGS, rdat); check(rdat, {26'h0, ef}, "flag clear");
        end
        wr(ADDR_FLAGS, 32'h3f);
        ef = 6'h00;
        // Interrupt raise, mask and read-clear
        wr(ADDR_IRQ_MASK, 32'h08);
        rd(ADDR_IRQ_MASK, rdat); check(rdat, 32'h08, "mask readback");
        rd(ADDR_IRQ_STATUS, rdat);
        fire(3, 3, 1'b1, n);
        repeat (2) @(posedge CLK_SYS);
        check(IRQ, 1'b1, "irq raised");
        rd(ADDR_IRQ_STATUS, rdat); check(rdat, 32'h08, "irq status");
        repeat (2) @(posedge CLK_SYS);
        check(IRQ, 1'b0, "irq cleared");
        fire(5, 3, 1'b1, n);
        check(IRQ, 1'b0, "irq masked");
        rd(ADDR_IRQ_STATUS, rdat); check(rdat, 32'h20, "masked status");
        ef = 6'h28;
        wr(ADDR_SWRESET, 32'h1);
        repeat (6) @(posedge CLK_SYS);
        check(CORE_RESET_N, 1'b1, "locked trigger");
        for (int k = 3; k <= 4; k++) begin
            wr(ADDR_GUARD, {24'h0, IO_UNLOCK_KEY});
            repeat (k) rd(ADDR_FLAGS, rdat);
            wr(ADDR_SWRESET, 32'h1);
            repeat (3) @(posedge CLK_SYS);
            check(CORE_RESET_N, k == 4, "trigger in window");
            wait_boot(n);
            if (k == 3) ef[BIT_SW] = 1'b1;
            rd(ADDR_FLAGS, rdat); check(rdat, {26'h0, ef}, "software flag");
        end
        STARTUP_SCAN_SELECT_FUSE <= 1'b1;
        @(posedge CLK_SYS);
        src[3] <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        src[3] <= 1'b0;
        n = 0;
        while (SCAN_START !== 1'b1 && n < 200) begin
            @(posedge CLK_SYS);
            n++;
        end
        check(SCAN_START, 1'b1, "scan start");
        check(CORE_RESET_N, 1'b0, "scan not awaited");
        repeat (20) begin
            @(posedge CLK_SYS);
            check(CORE_RESET_N, 1'b0, "held during scan");
        end
        SCAN_DONE <= 1'b1;
        wait_boot(n);
        SCAN_DONE <= 1'b0;
        STARTUP_SCAN_SELECT_FUSE <= 1'b0;
        @(posedge CLK_SYS);
        src[3] <= 1'b1;
        wr(ADDR_FLAGS, 32'h08);
        src[3] <= 1'b0;
        wait_boot(n);
        rd(ADDR_FLAGS, rdat); check(rdat, {26'h0, ef}, "set beats clear");
        STARTUP_DELAY_FUSE <= 3'h7;
        @(posedge CLK_SYS);
        src[0] <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        src[0] <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        src[3] <= 1'b1;
        @(posedge CLK_SYS);
        src[3] <= 1'b0;
        wait_boot(n);
        rd(ADDR_FLAGS, rdat); check(rdat, 32'h01, "power-on flags");
        check(cfg_low, 1'b1, "config reset on power-on");
        wr(ADDR_FLAGS, 32'h01);
        rd(ADDR_FLAGS, rdat); check(rdat, 32'h00, "power-on flag clear");
        finish_test();
    end
endmodule // reset_source_controller_tb
